// ==== rtl/frc_top.sv ====
// fixed reference control register bank with apb slave
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

module frc_top
#(
    parameter int          SETTLE_CYCLES = frc_pkg::FRC_SETTLE_CYCLES,
    parameter logic        SHUNT_VARIANT = 1'b0
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // sleep state of the device
    input  wire logic        wake_event,
    // analog controls
    output logic             ref_on,
    output logic             ref_ready_flag,
    output logic             pin_pass_gate_enable,
    output logic             pin_buffer_enable,
    output logic      [1:0]  pin_buffer_source_select,
    output logic      [3:0]  buffer_source_route,
    // reference output pin, digital side
    input  wire logic        pin_in,
    input  wire logic        pin_dig_out,
    input  wire logic        pin_dig_oe_n,
    output logic             pin_read,
    output logic             pin_out,
    output logic             pin_oe_n
);
    import frc_pkg::*;

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [31:0] prdata_reg;
    logic        access_phase;
    logic        wr_ctrl;
    logic        rd_any;
    logic        addr_ok;
    logic        pin_override;
    logic [7:0]  ctrl_view;
    logic        rd_wait_reg;

    // writes answer in the first access cycle; reads take one wait
    // state so that the read data can come straight from a flip-flop
    assign access_phase = psel & penable;
    assign addr_ok = (paddr == FRC_CTRL_OFFSET) |
                     (paddr == FRC_STATUS_OFFSET);
    assign wr_ctrl = access_phase & pwrite & pstrb[0] &
                     (paddr == FRC_CTRL_OFFSET);
    assign rd_any  = access_phase & ~pwrite;
    assign pready  = ~rd_any | rd_wait_reg;
    assign pslverr = access_phase & pready & ~addr_ok;

    // masked write value; ready and unused bits never stored
    assign ctrl_next = pwdata[7:0] & FRC_WRITE_MASK;

    // control register; wake_event is deliberately ignored here
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl_reg <= FRC_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_reg <= ctrl_next;
    end

    // ****************************************************************
    // reference enable and settling
    // ****************************************************************

    // shunt variant keeps the reference on regardless of the bit
    assign ref_on = ctrl_reg[FRC_BIT_ENABLE] | SHUNT_VARIANT;

    frc_settle
    #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    )
    u_settle
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .ref_on (ref_on),
        .ready  (ref_ready_flag)
    );

    // ****************************************************************
    // pin buffer and pass gate
    // ****************************************************************
    assign pin_pass_gate_enable     = ctrl_reg[FRC_BIT_PASS];
    assign pin_buffer_enable        = ctrl_reg[FRC_BIT_BUF_EN];
    assign pin_buffer_source_select = ctrl_reg[FRC_SEL_HI:FRC_SEL_LO];

    frc_pin_mux u_pin_mux
    (
        .pass_gate    (pin_pass_gate_enable),
        .buf_en       (pin_buffer_enable),
        .src_sel      (pin_buffer_source_select),
        .pin_in       (pin_in),
        .pin_dig_out  (pin_dig_out),
        .pin_dig_oe_n (pin_dig_oe_n),
        .src_onehot   (buffer_source_route),
        .pin_override (pin_override),
        .pin_read     (pin_read),
        .pin_out      (pin_out),
        .pin_oe_n     (pin_oe_n)
    );

    // ****************************************************************
    // read path
    // ****************************************************************

    // live ready flag merged into the stored bits
    always_comb
    begin
        ctrl_view = ctrl_reg;
        ctrl_view[FRC_BIT_READY] = ref_ready_flag;
    end

    // read wait flag: set by the first read access cycle, dropped by
    // the second, so every read answers exactly one cycle late
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd_wait_reg <= 1'b0;
        else
            rd_wait_reg <= rd_any & ~rd_wait_reg;
    end

    // registered read data, captured once per read and held after it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prdata_reg <= 32'h0000_0000;
        else if (rd_any & ~rd_wait_reg)
        begin
            if (paddr == FRC_CTRL_OFFSET)
                prdata_reg <= {24'h00_0000, ctrl_view};
            else if (paddr == FRC_STATUS_OFFSET)
                prdata_reg <= {30'h0000_0000, pin_override, ref_on};
            else
                prdata_reg <= 32'h0000_0000;
        end
    end

    // data straight from the flip-flop; stands with pready and after it
    assign prdata = prdata_reg;

endmodule

// ==== rtl/frc_pkg.sv ====
// package: register map, field layout and timing of the reference control
package frc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] FRC_CTRL_OFFSET  = 12'h000;
    localparam logic [11:0] FRC_STATUS_OFFSET = 12'h004;
    localparam logic [7:0]  FRC_CTRL_RESET   = 8'h00;

    // field positions of the control register
    localparam int FRC_BIT_ENABLE   = 7;
    localparam int FRC_BIT_READY    = 6;
    localparam int FRC_BIT_PASS     = 5;
    localparam int FRC_SEL_HI       = 4;
    localparam int FRC_SEL_LO       = 3;
    localparam int FRC_BIT_BUF_EN   = 0;

    // write mask: ready flag and bits 2-1 are not writable
    localparam logic [7:0]  FRC_WRITE_MASK = 8'hB9;

    // status register field positions (block-local choice)
    localparam int FRC_STAT_REF_ON  = 0;
    localparam int FRC_STAT_PIN_OVR = 1;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int FRC_CLK_MHZ       = 125;
    localparam int FRC_SETTLE_US     = 25;
    localparam int FRC_SETTLE_CYCLES = FRC_SETTLE_US * FRC_CLK_MHZ;

    // buffer source selections
    typedef enum logic [1:0]
    {
        FRC_SRC_BANDGAP = 2'h0,
        FRC_SRC_DAC     = 2'h1,
        FRC_SRC_AMP     = 2'h2,
        FRC_SRC_EXT_PIN = 2'h3
    } frc_src_t;

    // settle tracker states
    typedef enum logic [1:0]
    {
        FRC_ST_OFF,
        FRC_ST_SETTLING,
        FRC_ST_READY
    } frc_state_t;

endpackage

// ==== rtl/frc_settle.sv ====
// settle timer that raises the ready flag after the reference stabilises
`timescale 1ns/1ps

module frc_settle
#(
    parameter int SETTLE_CYCLES = frc_pkg::FRC_SETTLE_CYCLES
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control and result
    input  wire logic ref_on,
    output logic      ready
);
    import frc_pkg::*;

    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

    frc_state_t      state_reg;
    logic [CW-1:0]   count_reg;

    // state walk: off, settling, ready; drops back when disabled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= FRC_ST_OFF;
        else if (!ref_on)
            state_reg <= FRC_ST_OFF;
        else
        begin
            unique case (state_reg)
                FRC_ST_OFF:
                    state_reg <= FRC_ST_SETTLING;
                FRC_ST_SETTLING:
                    if (count_reg == LAST)
                        state_reg <= FRC_ST_READY;
                FRC_ST_READY:
                    state_reg <= FRC_ST_READY;
                default:
                    state_reg <= FRC_ST_OFF;
            endcase
        end
    end

    // cycle counter, cleared outside settling
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_reg <= '0;
        else if (ref_on && state_reg == FRC_ST_SETTLING)
            count_reg <= count_reg + CW'(1);
        else
            count_reg <= '0;
    end

    // low while off or settling
    assign ready = (state_reg == FRC_ST_READY) && ref_on;

endmodule

// ==== rtl/frc_pin_mux.sv ====
// pin buffer source routing and pin override
`timescale 1ns/1ps

module frc_pin_mux
(
    // configuration
    input  wire logic       pass_gate,
    input  wire logic       buf_en,
    input  wire logic [1:0] src_sel,
    // digital pin path
    input  wire logic       pin_in,
    input  wire logic       pin_dig_out,
    input  wire logic       pin_dig_oe_n,
    // results
    output logic [3:0]      src_onehot,
    output logic            pin_override,
    output logic            pin_read,
    output logic            pin_out,
    output logic            pin_oe_n
);
    import frc_pkg::*;

    // one-hot analog route for the buffer input
    always_comb
    begin
        src_onehot = 4'h0;
        unique case (frc_src_t'(src_sel))
            FRC_SRC_BANDGAP: src_onehot = 4'h1;
            FRC_SRC_DAC:     src_onehot = 4'h2;
            FRC_SRC_AMP:     src_onehot = 4'h4;
            FRC_SRC_EXT_PIN: src_onehot = 4'h8;
        endcase
    end

    // reference on the pin takes the pin from the digital side
    assign pin_override = buf_en | pass_gate;
    assign pin_read     = pin_override ? 1'b0 : pin_in;
    assign pin_out      = pin_override ? 1'b0 : pin_dig_out;
    assign pin_oe_n     = pin_override ? 1'b1 : pin_dig_oe_n;

endmodule

// ==== tb/frc_chk.sv ====
// assertion checker for the fixed reference control block
`timescale 1ns/1ps
module frc_chk
#(
    parameter int   SETTLE_CYCLES = 8,
    parameter logic SHUNT_VARIANT = 1'b0
)
(
    // clock and reset
    input logic        clk,
    input logic        rst_n,
    // apb request
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    // controls and pin
    input logic        ref_on,
    input logic        ref_ready_flag,
    input logic        pin_pass_gate_enable,
    input logic        pin_buffer_enable,
    input logic [1:0]  pin_buffer_source_select,
    input logic [3:0]  buffer_source_route,
    input logic        pin_in,
    input logic        pin_read,
    input logic        pin_oe_n
);
    int   on_cnt;
    logic wr;
    logic ovr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****
    // helper logic
    // ****
    assign wr  = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
    assign ovr = pin_buffer_enable || pin_pass_gate_enable;
    // cycles since enable, saturated so a long run cannot wrap
    always_ff @(posedge clk)
    begin
        if (!rst_n || !ref_on)
            on_cnt <= 0;
        else if (on_cnt <= SETTLE_CYCLES)
            on_cnt <= on_cnt + 1;
    end
    // ****
    // properties
    // ****
    property p_en; wr |=> ref_on == ($past(pwdata[7]) || SHUNT_VARIANT);
    endproperty
    a_en: assert property (p_en) else $error("bad enable");
    property p_gate; wr |=> pin_pass_gate_enable == $past(pwdata[5])
        && pin_buffer_enable == $past(pwdata[0]); endproperty
    a_gate: assert property (p_gate) else $error("bad gate");
    property p_sel;
        wr |=> pin_buffer_source_select == $past(pwdata[4:3]);
    endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_route;
        buffer_source_route == 4'h1 << pin_buffer_source_select;
    endproperty
    a_route: assert property (p_route) else $error("bad route");
    property p_hold; !wr |=> $stable({ref_on, pin_pass_gate_enable,
        pin_buffer_enable, pin_buffer_source_select}); endproperty
    a_hold: assert property (p_hold) else $error("bad hold");
    property p_ready;
        ref_ready_flag == (ref_on && on_cnt > SETTLE_CYCLES);
    endproperty
    a_ready: assert property (p_ready) else $error("bad ready");
    property p_pin; pin_read == (!ovr && pin_in); endproperty
    a_pin: assert property (p_pin) else $error("bad pin read");
    property p_oe; ovr |-> pin_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("bad pin drive");
    property p_rst; disable iff (1'b0) !rst_n |=> ref_on == SHUNT_VARIANT
        && !ovr && pin_buffer_source_select == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    c_ready: cover property (ref_ready_flag);
    c_both: cover property (pin_buffer_enable && pin_pass_gate_enable);
    c_ext: cover property (pin_buffer_source_select == 2'h3);
endmodule

bind frc_top frc_chk #(.SETTLE_CYCLES(SETTLE_CYCLES),
    .SHUNT_VARIANT(SHUNT_VARIANT)) frc_chk_inst (.clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .ref_on,
    .ref_ready_flag, .pin_pass_gate_enable, .pin_buffer_enable,
    .pin_buffer_source_select, .buffer_source_route, .pin_in, .pin_read,
    .pin_oe_n);

// ==== tb/tb.sv ====
// self-checking bench for the fixed reference control block
`timescale 1ns/1ps
module tb;
    localparam int S = 8;  // short settle keeps the run brief
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, er, wake_event = 0, pin_out;
    logic        ref_on, ref_ready_flag, pin_pass_gate_enable;
    logic        pin_buffer_enable, pin_read, pin_oe_n, shunt_ref_on;
    logic        pin_in = 1, pin_dig_out = 1, pin_dig_oe_n = 0;
    logic [1:0]  pin_buffer_source_select;
    logic [3:0]  pstrb = 0, buffer_source_route;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0]  wr_row [4] = '{8'h01, 8'h0F, 8'h76, 8'h19};
    logic [7:0]  rd_row [4] = '{8'h01, 8'h09, 8'h30, 8'h19};
    int          n_mismatch = 0, cmp_count = 0;

    // free-running 125 MHz clock
    always #4 clk = ~clk;

    frc_top #(.SETTLE_CYCLES(S)) frc_top_inst (.clk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .wake_event, .ref_on, .ref_ready_flag,
        .pin_pass_gate_enable, .pin_buffer_enable,
        .pin_buffer_source_select, .buffer_source_route, .pin_in,
        .pin_dig_out, .pin_dig_oe_n, .pin_read, .pin_out, .pin_oe_n);

    // second copy built as the shunt-regulator variant, same bus
    if (1)
    begin : shunt_blk
        frc_top #(.SETTLE_CYCLES(S), .SHUNT_VARIANT(1'b1)) frc_top_inst (
            .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
            .pstrb, .prdata(), .pready(), .pslverr(), .wake_event,
            .ref_on(shunt_ref_on), .ref_ready_flag(),
            .pin_pass_gate_enable(), .pin_buffer_enable(),
            .pin_buffer_source_select(), .buffer_source_route(), .pin_in,
            .pin_dig_out, .pin_dig_oe_n, .pin_read(), .pin_out(),
            .pin_oe_n());
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // one transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 16)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    // main sequence: table rows first, then the awkward cases
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1, 12'h000, {24'hFFFFFF, wr_row[i]}, 4'hF);
            apb(0, 12'h000, 0, 0);
            chk("ctrl", {24'h0, rd_row[i]}, rd);
            chk("route", 4'h1 << wr_row[i][4:3],
                buffer_source_route);
            chk("pin_read", 0, pin_read);
            chk("pin_out", 0, pin_out);
            $display("row %0d done", i);
        end
        // ready must still be low S cycles after the enable write
        apb(1, 12'h000, 32'h80, 4'h1);
        @(posedge clk);
        chk("ref_on", 1, ref_on);
        repeat (S - 1) @(posedge clk);
        chk("early", 0, ref_ready_flag);
        repeat (2) @(posedge clk);
        apb(0, 12'h000, 0, 0);
        chk("ready", 32'hC0, rd);
        $display("settle done");
        // strobe off, unmapped address and wake pulse change nothing
        apb(1, 12'h000, 32'h01, 4'hE);
        apb(1, 12'h008, 32'h01, 4'hF);
        chk("pslverr", 1, er);
        wake_event <= 1;
        @(posedge clk);
        wake_event <= 0;
        apb(0, 12'h000, 0, 0);
        chk("kept", 32'hC0, rd);
        $display("hold done");
        // disabling drops ready in the same cycle
        apb(1, 12'h000, 32'h21, 4'h1);
        @(posedge clk);
        chk("off", 0, {ref_on, ref_ready_flag});
        chk("oe_n", 1, pin_oe_n);
        chk("shunt_on", 1, shunt_ref_on);
        apb(0, 12'h004, 0, 0);
        chk("status", 32'h2, rd);
        // reset in mid-run clears the register and frees the pin
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, 12'h000, 0, 0);
        chk("reset", 0, rd);
        chk("oe_free", 0, pin_oe_n);
        chk("out_free", 1, pin_out);
        $display("reset done");
        wrap_up();
    end
endmodule
